// ---- design/ssrx_top.sv ----
// Synchronous serial port: master receive, slave transmit and receive
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module ssrx_top
	import ssrx_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Processor state
	input wire logic cpu_sleep,
	output logic wake_req,
	output logic irq_req,
	// Shift clock line
	input wire logic shift_clock_line_in,
	output logic shift_clock_line_out,
	output logic shift_clock_line_oe_n,
	// Serial data line
	input wire logic serial_data_line_in,
	output logic serial_data_line_out,
	output logic serial_data_line_oe_n
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] intctl_ff, pen_ff, baud_ff, txbuf_ff;
	logic serial_port_enable_ff, rx9_ff, sre_ff, cre_ff, ovr_ff;
	logic clock_source_select_ff, tx9_ff, transmit_enable_ff, sync_ff, t9d_ff;
	logic txfull_ff, tsrfull_ff;
	logic [8:0] tsr_ff, rsr_ff;
	logic [3:0] bitcnt_ff;
	logic [7:0] brg_ff;
	logic sclk_ff;
	logic [1:0] ck_sync_ff, dt_sync_ff;
	logic ck_prev_ff;
	ssrx_word_t fifo_ff [2];
	logic [1:0] fcnt_ff;
	logic [7:0] rdata_ff;
	ssrx_state_t state_ff, nxt_state;

	ssrx_bus_t bus;
	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	wire wr_rxstat = bus.wr && hit(bus.addr, ADDR_RXSTAT);
	wire wr_txstat = bus.wr && hit(bus.addr, ADDR_TXSTAT);
	wire wr_txbuf = bus.wr && hit(bus.addr, ADDR_TXBUF);
	wire rd_fifo = bus.rd && hit(bus.addr, ADDR_RXFIFO);
	wire master = clock_source_select_ff;
	wire rx_active_en = cre_ff || (sre_ff && master);
	wire any_en = transmit_enable_ff || cre_ff || sre_ff;
	wire port_on = serial_port_enable_ff && sync_ff;
	wire fifo_empty = (fcnt_ff == 2'd0);
	wire fifo_full = (fcnt_ff == 2'd2);
	wire [3:0] nbits = rx9_ff ? BITS_9 : BITS_8;
	wire [3:0] tbits = tx9_ff ? BITS_9 : BITS_8;

	// Shift clock: own divider in master, synced pin in slave
	wire brg_tick = (brg_ff == 8'h00);
	wire ck_now = master ? sclk_ff : ck_sync_ff[1];
	wire ck_fall = ck_prev_ff && !ck_now;
	wire ck_rise = !ck_prev_ff && ck_now;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	wire rx_last = (state_ff == ST_RX) && ck_fall && (bitcnt_ff == nbits - 4'd1);
	// Word ends on the fall after its last bit, so a cut frame never completes
	wire tx_last = (state_ff == ST_TX) && ck_fall && (bitcnt_ff == tbits);
	wire push = rx_last && !fifo_full && !ovr_ff;
	wire ovr_set = rx_last && fifo_full;
	wire tsr_load = txfull_ff && (!tsrfull_ff || tx_last);

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: if (port_on && rx_active_en) nxt_state = ST_RX;
				else if (port_on && transmit_enable_ff && tsrfull_ff) nxt_state = ST_TX;
			ST_TX: if (!port_on || rx_active_en || !transmit_enable_ff) nxt_state = ST_IDLE;
				else if (tx_last && !txfull_ff) nxt_state = ST_IDLE;
			ST_RX: if (!port_on || !rx_active_en) nxt_state = ST_IDLE;
				else if (rx_last && !cre_ff) nxt_state = ST_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// Pin synchronisers and baud generator
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ck_sync_ff <= 2'b00;
			dt_sync_ff <= 2'b00;
			ck_prev_ff <= 1'b0;
		end
		else
		begin
			ck_sync_ff <= {ck_sync_ff[0], shift_clock_line_in};
			dt_sync_ff <= {dt_sync_ff[0], serial_data_line_in};
			ck_prev_ff <= ck_now;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !any_en || !master)
		begin
			brg_ff <= RST_ZERO;
			sclk_ff <= 1'b0;
		end
		else if (brg_tick)
		begin
			brg_ff <= baud_ff;
			sclk_ff <= !sclk_ff;
		end
		else
			brg_ff <= brg_ff - 8'h01;
	end

	// ---------------------------------------------------------------
	// Shift registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state_ff <= ST_IDLE;
			bitcnt_ff <= 4'h0;
			rsr_ff <= 9'h000;
			tsr_ff <= 9'h000;
		end
		else
		begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff)
				bitcnt_ff <= 4'h0;
			else if (state_ff == ST_RX && ck_fall)
			begin
				rsr_ff <= {dt_sync_ff[1], rsr_ff[8:1]};
				bitcnt_ff <= rx_last ? 4'h0 : bitcnt_ff + 4'h1;
			end
			else if (tx_last)
				bitcnt_ff <= 4'h0;
			else if (state_ff == ST_TX && ck_rise)
				bitcnt_ff <= bitcnt_ff + 4'h1;
			if (tsr_load)
				tsr_ff <= {t9d_ff, txbuf_ff};
			else if (state_ff == ST_TX && ck_rise && bitcnt_ff != 4'h0)
				tsr_ff <= {1'b0, tsr_ff[8:1]};
		end
	end

	// Word as it lands: 8-bit mode has the byte in the top
	wire [8:0] rx_word = rx9_ff ? {dt_sync_ff[1], rsr_ff[8:1]} : {1'b0, dt_sync_ff[1], rsr_ff[8:2]};

	// ---------------------------------------------------------------
	// Receive FIFO
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			fcnt_ff <= 2'd0;
			fifo_ff[0] <= '0;
			fifo_ff[1] <= '0;
		end
		else
		begin
			if (rd_fifo && !fifo_empty)
				fifo_ff[0] <= fifo_ff[1];
			// A push during a pop lands one slot lower
			if (push)
				fifo_ff[(rd_fifo && !fifo_empty) ? fcnt_ff[0] ^ 1'b1 : fcnt_ff[0]] <=
					'{ninth: rx_word[8], data: rx_word[7:0]};
			fcnt_ff <= fcnt_ff + {1'b0, push} - {1'b0, rd_fifo && !fifo_empty};
		end
	end

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			{serial_port_enable_ff, rx9_ff, sre_ff, cre_ff, ovr_ff} <= 5'h00;
			{clock_source_select_ff, tx9_ff, transmit_enable_ff, sync_ff, t9d_ff} <= 5'h00;
			{intctl_ff, pen_ff, baud_ff, txbuf_ff} <= {4{RST_ZERO}};
			{txfull_ff, tsrfull_ff} <= 2'b00;
		end
		else
		begin
			if (wr_rxstat)
				{serial_port_enable_ff, rx9_ff, cre_ff} <= {bus.wdata[SERIAL_PORT_ENABLE_BIT], bus.wdata[RX9_BIT],
					bus.wdata[CRE_BIT]};
			if (wr_rxstat)
				sre_ff <= bus.wdata[SRE_BIT];
			else if (rx_last && master && !cre_ff)
				sre_ff <= 1'b0;
			if (ovr_set)
				ovr_ff <= 1'b1;
			else if (!cre_ff)
				ovr_ff <= 1'b0;
			if (wr_txstat)
				{clock_source_select_ff, tx9_ff, transmit_enable_ff, sync_ff, t9d_ff} <= {bus.wdata[CLOCK_SOURCE_SELECT_BIT],
					bus.wdata[TX9_BIT], bus.wdata[TRANSMIT_ENABLE_BIT], bus.wdata[SYNC_BIT],
					bus.wdata[T9D_BIT]};
			if (bus.wr && hit(bus.addr, ADDR_INTCTL))
				intctl_ff <= bus.wdata;
			if (bus.wr && hit(bus.addr, ADDR_PEN))
				pen_ff <= bus.wdata;
			if (bus.wr && hit(bus.addr, ADDR_BAUD))
				baud_ff <= bus.wdata;
			if (wr_txbuf)
				txbuf_ff <= bus.wdata;
			txfull_ff <= wr_txbuf || (txfull_ff && !tsr_load);
			if (!transmit_enable_ff)
				tsrfull_ff <= 1'b0;
			else
				tsrfull_ff <= tsr_load || (tsrfull_ff && !tx_last);
		end
	end

	// ---------------------------------------------------------------
	// Flags, interrupt and read path
	// ---------------------------------------------------------------
	wire rx_flag = !fifo_empty;
	wire tx_flag = !txfull_ff;
	wire [7:0] pflag = {2'b00, rx_flag, tx_flag, 4'h0};
	wire ev = (rx_flag && pen_ff[RXF_BIT]) || (tx_flag && pen_ff[TXF_BIT]);

	logic [7:0] rdata_next;
	always_comb
	begin
		unique case (bus.addr)
			ADDR_INTCTL: rdata_next = intctl_ff;
			ADDR_PFLAG: rdata_next = pflag;
			ADDR_RXSTAT: rdata_next = {serial_port_enable_ff, rx9_ff, sre_ff, cre_ff, 2'b00, ovr_ff,
				fifo_ff[0].ninth};
			ADDR_TXBUF: rdata_next = txbuf_ff;
			ADDR_RXFIFO: rdata_next = fifo_ff[0].data;
			ADDR_PEN: rdata_next = pen_ff;
			ADDR_TXSTAT: rdata_next = {clock_source_select_ff, tx9_ff, transmit_enable_ff, sync_ff, 2'b00,
				!tsrfull_ff, t9d_ff};
			ADDR_BAUD: rdata_next = baud_ff;
			default: rdata_next = RST_ZERO;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			rdata_ff <= RST_ZERO;
		else
			rdata_ff <= bus.rd ? rdata_next : RST_ZERO;
	end

	assign reg_rdata = rdata_ff;
	assign wake_req = cpu_sleep && ev;
	assign irq_req = ev && intctl_ff[GIE_BIT] && intctl_ff[PERIPHERAL_INTERRUPT_ENABLE_BIT];

	// ---------------------------------------------------------------
	// Pins: half duplex, clock only driven in master
	// ---------------------------------------------------------------
	assign shift_clock_line_out = sclk_ff;
	assign shift_clock_line_oe_n = !(port_on && master && any_en);
	assign serial_data_line_out = tsr_ff[0];
	assign serial_data_line_oe_n = !(state_ff == ST_TX);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence last_bit_full;
		rx_last && fifo_full;
	endsequence

	fifo_push_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		push && !rd_fifo |=> rx_flag && fcnt_ff == $past(fcnt_ff) + 2'd1)
		else $error("word not moved into fifo");
	overrun_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		last_bit_full |=> ovr_ff)
		else $error("overrun not flagged");
	overrun_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ovr_ff && cre_ff && !rd_fifo |=> fcnt_ff == $past(fcnt_ff))
		else $error("fifo changed under overrun");
	flag_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rd_fifo && fcnt_ff == 2'd1 && !push |=> !rx_flag)
		else $error("receive flag stuck");
	single_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rx_last && master && !cre_ff && !wr_rxstat |=> !sre_ff ##1 state_ff != ST_RX)
		else $error("single receive did not stop");
	slave_ignore_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!master && !cre_ff |=> state_ff != ST_RX)
		else $error("slave used single enable");
	brg_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!any_en [*2] |-> brg_ff == 8'h00 && !sclk_ff)
		else $error("baud generator running");
	duplex_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rx_active_en && state_ff == ST_TX |=> serial_data_line_oe_n)
		else $error("data line still driven");

	// Receive path
	rx_sample_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state_ff == ST_RX && ck_fall && nxt_state == ST_RX
			|=> rsr_ff[8] == $past(dt_sync_ff[1]))
		else $error("bit not sampled on falling edge");
	head_shift_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rd_fifo && fifo_full |=> fifo_ff[0] == $past(fifo_ff[1]))
		else $error("next entry not at head");
	fifo_order_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		push && fcnt_ff == 2'd1 && !rd_fifo |=> fifo_ff[0] == $past(fifo_ff[0]))
		else $error("older entry overwritten");
	overrun_discard_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rx_last && fifo_full && !rd_fifo |=> fifo_full && fifo_ff[1] == $past(fifo_ff[1]))
		else $error("overrun word not discarded");
	overrun_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!cre_ff && !ovr_set |=> !ovr_ff)
		else $error("overrun not cleared");

	// Transmit path and clock
	sequence tx_word_done;
		tx_last && txfull_ff && transmit_enable_ff && !wr_txbuf;
	endsequence

	tx_flag_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		txfull_ff && tsrfull_ff && !tx_last |=> !tx_flag)
		else $error("transmit flag set early");
	tx_reload_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		tx_word_done |=> tsrfull_ff && tx_flag)
		else $error("second word not loaded");
	brg_reload_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		master && any_en && brg_tick |=> brg_ff == $past(baud_ff))
		else $error("shift clock half period wrong");

endmodule : ssrx_top

// ---- common/ssrx_pkg.sv ----
// Package: register map, field positions and reset values for the serial port
package ssrx_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_INTCTL = 8'h0b;
	localparam logic [7:0] ADDR_PFLAG = 8'h0c;
	localparam logic [7:0] ADDR_RXSTAT = 8'h18;
	localparam logic [7:0] ADDR_TXBUF = 8'h19;
	localparam logic [7:0] ADDR_RXFIFO = 8'h1a;
	localparam logic [7:0] ADDR_PEN = 8'h8c;
	localparam logic [7:0] ADDR_TXSTAT = 8'h98;
	localparam logic [7:0] ADDR_BAUD = 8'h99;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int GIE_BIT = 7;
	localparam int PERIPHERAL_INTERRUPT_ENABLE_BIT = 6;
	localparam int RXF_BIT = 5;
	localparam int TXF_BIT = 4;
	localparam int SERIAL_PORT_ENABLE_BIT = 7;
	localparam int RX9_BIT = 6;
	localparam int SRE_BIT = 5;
	localparam int CRE_BIT = 4;
	localparam int FRAMING_ERROR_FLAG_BIT = 2;
	localparam int OVR_BIT = 1;
	localparam int R9D_BIT = 0;
	localparam int CLOCK_SOURCE_SELECT_BIT = 7;
	localparam int TX9_BIT = 6;
	localparam int TRANSMIT_ENABLE_BIT = 5;
	localparam int SYNC_BIT = 4;
	localparam int TRMT_BIT = 1;
	localparam int T9D_BIT = 0;

	// ---------------------------------------------------------------
	// Reset values and counts
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TXSTAT = 8'h02;
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ssrx_bus_t;

	typedef struct packed {
		logic ninth;
		logic [7:0] data;
	} ssrx_word_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_TX = 2'b01,
		ST_RX = 2'b11
	} ssrx_state_t;

endpackage : ssrx_pkg

// ---- test/ssrx_peer.sv ----
// Far-side peer model: shift clock source and serial data partner
`timescale 1ns/1ps
module ssrx_peer
(
	// Link lines
	output logic peer_clk,
	output logic peer_data,
	output logic peer_drive,
	input wire logic line_data,
	input wire logic line_clk
);
	logic [8:0] got_word;
	// ----------
	// Frames
	// ----------
	initial
	begin
		peer_clk = 1'b0;
		peer_data = 1'b1;
		peer_drive = 1'b0;
		got_word = 9'h000;
	end
	// Clock stands low between frames; a released data line goes to its pull-up
	task automatic frame(input logic [8:0] w, input int n, input logic drv);
		peer_drive = drv;
		for (int i = 0; i < n; i++)
		begin
			peer_clk = 1'b1;
			#50 peer_data = w[i];
			#50 got_word[i] = line_data;
			peer_clk = 1'b0;
			#100;
		end
		peer_drive = 1'b0;
	endtask : frame
	// Master mode: next bit after each rising edge of the device's clock
	task automatic follow(input logic [8:0] w, input int n);
		peer_drive = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			for (int t = 0; t < 100 && !line_clk; t++)
				#5;
			peer_data = w[i];
			for (int t = 0; t < 100 && line_clk; t++)
				#5;
		end
		peer_drive = 1'b0;
	endtask : follow
endmodule : ssrx_peer

// ---- test/testbench.sv ----
// Testbench: register driver, link partner and checks for the serial port
`timescale 1ns/1ps
module testbench
	import ssrx_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cpu_sleep = 1'b0;
	logic [7:0] reg_rdata;
	logic wake_req, irq_req, ck_out, ck_oe_n, dt_out, dt_oe_n;
	logic peer_clk, peer_data, peer_drive;
	logic [15:0] seed = 16'h6cf8;
	logic [8:0] w [0:3];
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	wire ck_line = ck_oe_n ? peer_clk : ck_out;
	wire dt_line = !dt_oe_n ? dt_out : (peer_drive ? peer_data : 1'b1);

	always #12.5 sys_clk = ~sys_clk;

	ssrx_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_sleep(cpu_sleep), .wake_req(wake_req), .irq_req(irq_req),
		.shift_clock_line_in(ck_line), .shift_clock_line_out(ck_out),
		.shift_clock_line_oe_n(ck_oe_n), .serial_data_line_in(dt_line),
		.serial_data_line_out(dt_out), .serial_data_line_oe_n(dt_oe_n));
	ssrx_peer i_peer (.peer_clk(peer_clk), .peer_data(peer_data),
		.peer_drive(peer_drive), .line_data(dt_line), .line_clk(ck_line));

	// ----------
	// Helpers
	// ----------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// Status with port on, nine-bit, both enables written as one
	function automatic logic [7:0] stat(input logic ovr, input logic nb);
		return {6'b111100, ovr, nb};
	endfunction : stat
	task automatic stop_test;
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, seen);
			miscompares++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), exp, reg_rdata & m);
	endtask : rc

	// Hang guard
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			miscompares++;
			stop_test();
		end
	end

	// ----------
	// Scenarios
	// ----------
	initial
	begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rc(ADDR_TXSTAT, 8'hff, RST_TXSTAT);
		rc(ADDR_BAUD, 8'hff, RST_ZERO);
		rc(8'h55, 8'hff, 8'h00);
		wr(ADDR_BAUD, 8'h03);
		wr(ADDR_TXSTAT, 8'h90);
		wr(ADDR_RXSTAT, 8'h80);
		wr(ADDR_RXSTAT, 8'ha0);
		#1;
		chk("ck_oe_n", 8'h00, {7'h00, ck_oe_n});
		seed = lfsr(seed);
		i_peer.follow(seed[8:0], 8);
		repeat (8) @(posedge sys_clk);
		rc(ADDR_RXSTAT, 8'h21, 8'h00);
		chk("ck_oe_n", 8'h01, {7'h00, ck_oe_n});
		rc(ADDR_PFLAG, 8'h20, 8'h20);
		rc(ADDR_RXFIFO, 8'hff, seed[7:0]);
		wr(ADDR_TXSTAT, 8'h10);
		wr(ADDR_RXSTAT, 8'hf0);
		wr(ADDR_PEN, 8'h20);
		wr(ADDR_INTCTL, 8'hc0);
		rc(ADDR_PEN, 8'hff, 8'h20);
		for (int k = 0; k < 3; k++)
		begin
			seed = lfsr(seed);
			w[k] = seed[8:0];
			i_peer.frame(w[k], 9, 1'b1);
			repeat (8) @(posedge sys_clk);
			chk("irq_req", 8'h01, {7'h00, irq_req});
			rc(ADDR_PFLAG, 8'h20, 8'h20);
		end
		rc(ADDR_RXSTAT, 8'hff, stat(1'b1, w[0][8]));
		rc(ADDR_RXFIFO, 8'hff, w[0][7:0]);
		rc(ADDR_RXSTAT, 8'h01, {7'h00, w[1][8]});
		rc(ADDR_RXFIFO, 8'hff, w[1][7:0]);
		rc(ADDR_PFLAG, 8'h20, 8'h00);
		wr(ADDR_PFLAG, 8'h20);
		rc(ADDR_PFLAG, 8'h20, 8'h00);
		i_peer.frame(9'h1a5, 9, 1'b1);
		repeat (8) @(posedge sys_clk);
		rc(ADDR_PFLAG, 8'h20, 8'h00);
		wr(ADDR_RXSTAT, 8'he0);
		wr(ADDR_RXSTAT, 8'hf0);
		rc(ADDR_RXSTAT, 8'h02, 8'h00);
		@(posedge sys_clk);
		cpu_sleep <= 1'b1;
		seed = lfsr(seed);
		w[3] = seed[8:0];
		i_peer.frame(w[3], 9, 1'b1);
		repeat (8) @(posedge sys_clk);
		chk("wake_req", 8'h01, {7'h00, wake_req});
		wr(ADDR_PEN, 8'h00);
		#1;
		chk("wake_req", 8'h00, {7'h00, wake_req});
		chk("irq_req", 8'h00, {7'h00, irq_req});
		rc(ADDR_PFLAG, 8'h20, 8'h20);
		rc(ADDR_RXFIFO, 8'hff, w[3][7:0]);
		@(posedge sys_clk);
		cpu_sleep <= 1'b0;
		wr(ADDR_RXSTAT, 8'h80);
		wr(ADDR_TXSTAT, 8'h30);
		wr(ADDR_PEN, 8'h10);
		seed = lfsr(seed);
		wr(ADDR_TXBUF, seed[7:0]);
		wr(ADDR_TXBUF, seed[15:8]);
		@(posedge sys_clk);
		cpu_sleep <= 1'b1;
		rc(ADDR_PFLAG, 8'h10, 8'h00);
		chk("wake_req", 8'h00, {7'h00, wake_req});
		i_peer.frame(9'h000, 8, 1'b0);
		repeat (8) @(posedge sys_clk);
		chk("tx word", seed[7:0], i_peer.got_word[7:0]);
		#1;
		chk("wake_req", 8'h01, {7'h00, wake_req});
		rc(ADDR_PFLAG, 8'h10, 8'h10);
		i_peer.frame(9'h000, 8, 1'b0);
		chk("tx word", seed[15:8], i_peer.got_word[7:0]);
		stop_test();
	end
endmodule : testbench
